/* File: core/compact_timer_pkg.sv */
package compact_timer_pkg;

	typedef enum logic [1:0] {
		MODE_CMP   = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_PWM   = 2'h2,
		MODE_TIMER = 2'h3
	} mode_t;

	typedef struct packed {
		logic       pause;
		logic [2:0] cksel;
		logic       on;
		logic [2:0] rsvd;
	} ctrl0_t;

	typedef struct packed {
		mode_t      mode;
		logic [1:0] io;
		logic       ctoc;
		logic       pol;
		logic       dpx;
		logic       cclr;
	} ctrl1_t;

	localparam logic [2:0] ADDR_CTRL0  = 3'h0;
	localparam logic [2:0] ADDR_CTRL1  = 3'h1;
	localparam logic [2:0] ADDR_CNT_LO = 3'h2;
	localparam logic [2:0] ADDR_CNT_HI = 3'h3;
	localparam logic [2:0] ADDR_CMP_LO = 3'h4;
	localparam logic [2:0] ADDR_CMP_HI = 3'h5;
	localparam logic [2:0] ADDR_PERIOD = 3'h6;

	localparam ctrl0_t      CTRL0_RST  = 8'h00;
	localparam ctrl1_t      CTRL1_RST  = 8'h00;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hffff;
	localparam logic [15:0] CNT_STEP   = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [2:0]  RSVD_ZERO  = 3'h0;

	localparam logic [2:0] CKS_SYS4     = 3'h0;
	localparam logic [2:0] CKS_SYS      = 3'h1;
	localparam logic [2:0] CKS_HI16     = 3'h2;
	localparam logic [2:0] CKS_HI64     = 3'h3;
	localparam logic [2:0] CKS_SUB0     = 3'h4;
	localparam logic [2:0] CKS_SUB1     = 3'h5;
	localparam logic [2:0] CKS_EXT_RISE = 3'h6;
	localparam logic [2:0] CKS_EXT_FALL = 3'h7;

	localparam logic [5:0] PRE_ZERO  = 6'h00;
	localparam logic [5:0] PRE_STEP  = 6'h01;
	localparam logic [5:0] DIV4_MASK  = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0f;
	localparam logic [5:0] DIV64_MASK = 6'h3f;

	localparam logic [1:0] IO_NONE   = 2'h0;
	localparam logic [1:0] IO_LOW    = 2'h1;
	localparam logic [1:0] IO_HIGH   = 2'h2;
	localparam logic [1:0] IO_TOGGLE = 2'h3;
	localparam logic [1:0] PWM_ACT   = 2'h1;
	localparam logic [1:0] PWM_WAVE  = 2'h2;

endpackage

/* File: core/edge_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic level_in,
	output logic      rise_out,
	output logic      fall_out
);
	logic meta;
	logic sync;
	logic last;

	// Two-stage synchroniser, then one stage for edge compare
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= level_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign rise_out = sync & ~last;
	assign fall_out = ~sync & last;
endmodule
`default_nettype wire

/* File: core/compact_timer_core.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module compact_timer_core
	import compact_timer_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic       external_timer_clock_pin_in,
	input  wire logic       subsidiary_clock_in,
	output logic      [7:0] rdata_out,
	output logic            timer_output_pin_out,
	output logic            match_a_irq_out,
	output logic            match_p_irq_out
);

	////////////////////////////////////////////////////////////////
	// State

	ctrl0_t      ctrl0;
	ctrl1_t      ctrl1;
	logic [15:0] cnt;
	logic [15:0] cmpa;
	logic [7:0]  period;
	logic [7:0]  buffer;
	logic [5:0]  prescale;
	logic        on_q;
	logic        pin_state;

	////////////////////////////////////////////////////////////////
	// Register decode

	wire wr_c0   = wr_in & (addr_in == ADDR_CTRL0);
	wire wr_c1   = wr_in & (addr_in == ADDR_CTRL1);
	wire wr_alo  = wr_in & (addr_in == ADDR_CMP_LO);
	wire wr_ahi  = wr_in & (addr_in == ADDR_CMP_HI);
	wire wr_per  = wr_in & (addr_in == ADDR_PERIOD);
	wire rd_dhi  = rd_in & (addr_in == ADDR_CNT_HI);
	wire rd_ahi  = rd_in & (addr_in == ADDR_CMP_HI);

	// Low bytes always read the shared buffer
	wire [7:0] rd_word =
		(addr_in == ADDR_CTRL0)  ? ctrl0 :
		(addr_in == ADDR_CTRL1)  ? ctrl1 :
		(addr_in == ADDR_CNT_LO) ? buffer :
		(addr_in == ADDR_CNT_HI) ? cnt[15:8] :
		(addr_in == ADDR_CMP_LO) ? buffer :
		(addr_in == ADDR_CMP_HI) ? cmpa[15:8] :
		(addr_in == ADDR_PERIOD) ? period : BYTE_ZERO;

	wire [7:0] next_buffer =
		wr_alo ? wdata_in :
		rd_dhi ? cnt[7:0] :
		rd_ahi ? cmpa[7:0] :
		buffer;

	wire ctrl0_t next_ctrl0 = {wdata_in[7:3], RSVD_ZERO};

	////////////////////////////////////////////////////////////////
	// Clock source

	logic ext_rise;
	logic ext_fall;
	logic sub_rise;

	edge_sync ext_sync (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.level_in (external_timer_clock_pin_in),
		.rise_out (ext_rise),
		.fall_out (ext_fall)
	);

	edge_sync sub_sync (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.level_in (subsidiary_clock_in),
		.rise_out (sub_rise),
		.fall_out ()
	);

	wire tick4  = (prescale & DIV4_MASK) == DIV4_MASK;
	wire tick16 = (prescale & DIV16_MASK) == DIV16_MASK;
	wire tick64 = (prescale & DIV64_MASK) == DIV64_MASK;

	wire src_tick =
		(ctrl0.cksel == CKS_SYS4)     ? tick4 :
		(ctrl0.cksel == CKS_SYS)      ? 1'b1 :
		(ctrl0.cksel == CKS_HI16)     ? tick16 :
		(ctrl0.cksel == CKS_HI64)     ? tick64 :
		(ctrl0.cksel == CKS_SUB0)     ? sub_rise :
		(ctrl0.cksel == CKS_SUB1)     ? sub_rise :
		(ctrl0.cksel == CKS_EXT_RISE) ? ext_rise :
		ext_fall;

	////////////////////////////////////////////////////////////////
	// Counter and comparators

	wire cmp_mode = ctrl1.mode == MODE_CMP;
	wire pwm_mode = ctrl1.mode == MODE_PWM;
	wire on_rise  = ctrl0.on & ~on_q;
	wire cnt_run  = ctrl0.on & ~ctrl0.pause & src_tick;

	wire hit_a    = cnt == cmpa;
	wire per_zero = period == BYTE_ZERO;
	wire hit_p    = ~per_zero & (cnt[15:8] == period)
		& (cnt[7:0] == BYTE_ZERO);
	wire ovf      = per_zero & (cnt == CNT_MAX);
	wire p_or_ovf = hit_p | ovf;

	wire a_event  = cnt_run & hit_a;
	wire p_event  = cnt_run & p_or_ovf;

	// PWM clears on whichever comparator sets the period
	wire clr_hit  = pwm_mode ? (ctrl1.dpx ? hit_a : p_or_ovf) :
		(ctrl1.cclr ? hit_a : p_or_ovf);
	wire clr_now  = cnt_run & clr_hit;

	wire [15:0] next_cnt =
		on_rise ? CNT_ZERO :
		clr_now ? CNT_ZERO :
		cnt_run ? cnt + CNT_STEP :
		cnt;

	////////////////////////////////////////////////////////////////
	// Output pin

	wire cmp_level =
		(ctrl1.io == IO_HIGH)   ? 1'b1 :
		(ctrl1.io == IO_LOW)    ? 1'b0 :
		(ctrl1.io == IO_TOGGLE) ? ~pin_state :
		pin_state;

	wire cmp_next =
		on_rise ? ctrl1.ctoc :
		a_event ? cmp_level :
		pin_state;

	wire duty_on = ctrl1.dpx ? (cnt[15:8] < period) : (cnt < cmpa);

	wire pwm_active = (ctrl1.io == PWM_ACT)
		| ((ctrl1.io == PWM_WAVE) & ctrl0.on & duty_on);

	wire pwm_next = pwm_active ? ctrl1.ctoc : ~ctrl1.ctoc;

	wire next_pin =
		pwm_mode ? pwm_next :
		cmp_mode ? cmp_next :
		1'b0;

	wire drive_pin = cmp_mode | pwm_mode;

	////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl0 <= CTRL0_RST;
			ctrl1 <= CTRL1_RST;
			period <= BYTE_ZERO;
			cmpa <= CNT_ZERO;
		end else begin
			if (wr_c0) begin
				ctrl0 <= next_ctrl0;
			end
			if (wr_c1) begin
				ctrl1 <= ctrl1_t'(wdata_in);
			end
			if (wr_per) begin
				period <= wdata_in;
			end
			if (wr_ahi) begin
				cmpa <= {wdata_in, buffer};
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			buffer <= BYTE_ZERO;
			rdata_out <= BYTE_ZERO;
		end else begin
			buffer <= next_buffer;
			rdata_out <= rd_in ? rd_word : BYTE_ZERO;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= CNT_ZERO;
			prescale <= PRE_ZERO;
			on_q <= 1'b0;
		end else begin
			cnt <= next_cnt;
			prescale <= prescale + PRE_STEP;
			on_q <= ctrl0.on;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pin_state <= 1'b0;
			timer_output_pin_out <= 1'b0;
			match_a_irq_out <= 1'b0;
			match_p_irq_out <= 1'b0;
		end else begin
			pin_state <= next_pin;
			timer_output_pin_out <= drive_pin & (next_pin ^ ctrl1.pol);
			match_a_irq_out <= a_event;
			match_p_irq_out <= p_event;
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_toggle_hit;
		a_event && cmp_mode && !on_rise && (ctrl1.io == IO_TOGGLE) && !wr_in;
	endsequence

	sequence s_pin_flipped;
		##1 timer_output_pin_out != $past(timer_output_pin_out);
	endsequence

	sequence s_hi_read;
		rd_dhi;
	endsequence

	a_on_clears_cnt: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$rose(ctrl0.on) |=> cnt == CNT_ZERO
	) else $error("counter not cleared when switched on");

	a_pause_holds: assert property (
		@(posedge clock_in) disable iff (rst_in)
		ctrl0.pause && !on_rise |=> cnt == $past(cnt)
	) else $error("counter moved while paused");

	a_count_step: assert property (
		@(posedge clock_in) disable iff (rst_in)
		cnt_run && !clr_now && !on_rise |=> cnt == $past(cnt) + CNT_STEP
	) else $error("counter did not step by one");

	a_a_match_irq: assert property (
		@(posedge clock_in) disable iff (rst_in)
		cnt_run && (cnt == cmpa) |=> match_a_irq_out
	) else $error("compare A match gave no interrupt");

	a_p_match_irq: assert property (
		@(posedge clock_in) disable iff (rst_in)
		cnt_run && (period != BYTE_ZERO) && (cnt[15:8] == period)
			&& (cnt[7:0] == BYTE_ZERO) |=> match_p_irq_out
	) else $error("period match gave no interrupt");

	a_clear_on_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		cnt_run && ctrl1.cclr && !pwm_mode && (cnt == cmpa)
			|=> cnt == CNT_ZERO
	) else $error("compare A match did not clear counter");

	a_cmp_hi_write: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_ahi |=> cmpa == {$past(wdata_in), $past(buffer)}
	) else $error("compare high write did not load both bytes");

	a_cmp_lo_write: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_alo |=> $stable(cmpa) && (buffer == $past(wdata_in))
	) else $error("compare low write touched the register");

	a_hi_read_capture: assert property (
		@(posedge clock_in) disable iff (rst_in)
		s_hi_read |=> (buffer == $past(cnt[7:0]))
			&& (rdata_out == $past(cnt[15:8]))
	) else $error("counter high read did not capture low byte");

	a_lo_read_buffer: assert property (
		@(posedge clock_in) disable iff (rst_in)
		rd_in && (addr_in == ADDR_CNT_LO) |=> rdata_out == $past(buffer)
	) else $error("low byte read did not return buffer");

	a_toggle_pin: assert property (
		@(posedge clock_in) disable iff (rst_in)
		s_toggle_hit |-> s_pin_flipped
	) else $error("toggle on compare match did not flip pin");

	a_ext_edge_tick: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(ctrl0.cksel == CKS_EXT_FALL) && ctrl0.on && !ctrl0.pause
			&& !on_rise && !clr_hit && !$past(external_timer_clock_pin_in, 2)
			&& $past(external_timer_clock_pin_in, 3)
			|=> cnt == $past(cnt) + CNT_STEP
	) else $error("falling external edge did not advance counter");

	a_ext_no_edge: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(ctrl0.cksel == CKS_EXT_RISE) && !on_rise
			&& ($past(external_timer_clock_pin_in, 2)
			== $past(external_timer_clock_pin_in, 3))
			|=> cnt == $past(cnt)
	) else $error("counter moved without an external edge");

	a_cmp_set_high: assert property (
		@(posedge clock_in) disable iff (rst_in)
		a_event && cmp_mode && !on_rise && (ctrl1.io == IO_HIGH)
			|=> timer_output_pin_out == !$past(ctrl1.pol)
	) else $error("set-high compare match did not raise pin");

	a_cmp_set_low: assert property (
		@(posedge clock_in) disable iff (rst_in)
		a_event && cmp_mode && !on_rise && (ctrl1.io == IO_LOW)
			|=> timer_output_pin_out == $past(ctrl1.pol)
	) else $error("set-low compare match did not lower pin");

	a_on_pin_init: assert property (
		@(posedge clock_in) disable iff (rst_in)
		on_rise && cmp_mode
			|=> timer_output_pin_out == ($past(ctrl1.ctoc) ^ $past(ctrl1.pol))
	) else $error("pin not set to initial level when switched on");

	a_pwm_active_pin: assert property (
		@(posedge clock_in) disable iff (rst_in)
		pwm_mode && (ctrl1.io == PWM_ACT)
			|=> timer_output_pin_out == ($past(ctrl1.ctoc) ^ $past(ctrl1.pol))
	) else $error("forced active level missing on output pin");

	a_idle_pin_low: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!cmp_mode && !pwm_mode |=> !timer_output_pin_out
	) else $error("output pin driven outside compare and PWM modes");

	a_period_clear: assert property (
		@(posedge clock_in) disable iff (rst_in)
		cnt_run && !ctrl1.cclr && !pwm_mode && hit_p
			|=> cnt == CNT_ZERO
	) else $error("period match did not clear counter");

	a_buffer_hold: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!wr_alo && !rd_dhi && !rd_ahi |=> $stable(buffer)
	) else $error("shared buffer changed without a transfer");

	a_write_no_load: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_in && !on_rise && !cnt_run |=> $stable(cnt)
	) else $error("register write changed the counter");

endmodule
`default_nettype wire

/* File: tb/pin_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
	input  wire logic clock_in,
	output logic      external_timer_clock_pin_out,
	output logic      subsidiary_clock_out
);
	initial begin
		external_timer_clock_pin_out = 1'b0;
		subsidiary_clock_out = 1'b0;
	end

	// Slow oscillator, one period every 16 system cycles
	always begin
		repeat (8) @(posedge clock_in);
		subsidiary_clock_out <= ~subsidiary_clock_out;
	end

	// Each level held 4 cycles so the synchroniser sees every edge
	task automatic pulse(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock_in);
			external_timer_clock_pin_out <= 1'b1;
			repeat (4) @(posedge clock_in);
			external_timer_clock_pin_out <= 1'b0;
		end
		repeat (6) @(posedge clock_in);
	endtask
endmodule
`default_nettype wire

/* File: tb/compact_timer_core_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module compact_timer_core_bench;
	import compact_timer_pkg::*;
	logic       clk;
	logic       rst;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       ext_pin;
	logic       sub_clk;
	logic [7:0] rdata;
	logic       pin;
	logic       irq_a;
	logic       irq_p;
	int         mismatches;
	int         checks;
	int         ones;
	logic [2:0] cks[6]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	logic [7:0] cmp[6]  = '{8'h03, 8'h10, 8'h01, 8'h01, 8'h02, 8'h02};
	logic [7:0] c1[6]   = '{8'h21, 8'h31, 8'h19, 8'h21, 8'h31, 8'h19};
	logic       pend[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	int         gap[6]  = '{16, 17, 32, 128, 48, 48};

	compact_timer_core uut (
		.clock_in                    (clk),
		.rst_in                      (rst),
		.addr_in                     (addr),
		.wdata_in                    (wdata),
		.wr_in                       (wr),
		.rd_in                       (rd),
		.external_timer_clock_pin_in (ext_pin),
		.subsidiary_clock_in         (sub_clk),
		.rdata_out                   (rdata),
		.timer_output_pin_out        (pin),
		.match_a_irq_out             (irq_a),
		.match_p_irq_out             (irq_p)
	);

	pin_partner partner (
		.clock_in                     (clk),
		.external_timer_clock_pin_out (ext_pin),
		.subsidiary_clock_out         (sub_clk)
	);

	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: pin %b expected %b", $time, got, exp);
		end
	endtask

	task automatic check_gap(input int got, input int exp);
		checks++;
		if (got != exp) begin
			mismatches++;
			$display("Error %0t: gap %0d expected %0d", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check8(rdata, exp);
	endtask

	// High byte first, then the buffered low byte
	task automatic rd16(input logic [2:0] hi, input logic [15:0] exp);
		rd_reg(hi, exp[15:8]);
		rd_reg(hi - 3'h1, exp[7:0]);
	endtask

	task automatic wait_irq(input logic sel_a);
		int i;
		i = 0;
		@(negedge clk);
		while (((sel_a ? irq_a : irq_p) !== 1'b1) && i < 20000) begin
			@(negedge clk);
			i++;
		end
		if (i >= 20000) begin
			mismatches++;
			$display("Error %0t: no match event", $time);
		end
	endtask

	task automatic measure(input logic sel_a, input int exp);
		int n;
		wait_irq(sel_a);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (((sel_a ? irq_a : irq_p) !== 1'b1) && n < 20000);
		check_gap(n, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 40000);
		mismatches++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		mismatches = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ADDR_CTRL0, 8'h00);
		rd_reg(ADDR_CTRL1, 8'h00);
		rd_reg(3'h7, 8'h00);
		wr_reg(ADDR_CTRL0, 8'hf7);
		rd_reg(ADDR_CTRL0, 8'hf0);
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CMP_LO, 8'h34);
		rd_reg(ADDR_CMP_LO, 8'h34);
		rd_reg(ADDR_CMP_HI, 8'h00);
		rd_reg(ADDR_CMP_LO, 8'h00);
		wr_reg(ADDR_CMP_LO, 8'h34);
		wr_reg(ADDR_CMP_HI, 8'h12);
		rd16(ADDR_CMP_HI, 16'h1234);
		rd_reg(ADDR_CNT_LO, 8'h34);
		for (int k = 0; k < 6; k++) begin
			wr_reg(ADDR_CTRL0, 8'h00);
			wr_reg(ADDR_CTRL1, c1[k]);
			wr_reg(ADDR_CMP_LO, cmp[k]);
			wr_reg(ADDR_CMP_HI, 8'h00);
			wr_reg(ADDR_CTRL0, {1'b0, cks[k], 1'b1, 3'h0});
			repeat (2) @(negedge clk);
			check1(pin, ~pend[k]);
			measure(1'b1, gap[k]);
			wait_irq(1'b1);
			check1(pin, pend[k]);
		end
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CTRL1, 8'h00);
		wr_reg(ADDR_PERIOD, 8'h01);
		wr_reg(ADDR_CTRL0, 8'h18);
		measure(1'b0, 257);
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CTRL1, 8'haa);
		wr_reg(ADDR_CMP_LO, 8'h00);
		wr_reg(ADDR_CMP_HI, 8'h02);
		wr_reg(ADDR_CTRL0, 8'h18);
		repeat (600) @(negedge clk);
		ones = 0;
		repeat (513) begin
			@(negedge clk);
			ones += (pin === 1'b1) ? 1 : 0;
		end
		check_gap(ones, 256);
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CTRL1, 8'h5c);
		repeat (2) @(negedge clk);
		check1(pin, 1'b0);
		wr_reg(ADDR_CTRL1, 8'h98);
		repeat (2) @(negedge clk);
		check1(pin, 1'b1);
		wr_reg(ADDR_CTRL1, 8'h9c);
		repeat (2) @(negedge clk);
		check1(pin, 1'b0);
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CTRL1, 8'hc0);
		wr_reg(ADDR_CMP_LO, 8'hff);
		wr_reg(ADDR_CMP_HI, 8'hff);
		wr_reg(ADDR_CTRL0, 8'h68);
		partner.pulse(5);
		wr_reg(ADDR_CNT_HI, 8'h55);
		rd16(ADDR_CNT_HI, 16'h0005);
		check1(pin, 1'b0);
		wr_reg(ADDR_CTRL0, 8'he8);
		partner.pulse(4);
		wr_reg(ADDR_CTRL0, 8'h68);
		partner.pulse(2);
		rd16(ADDR_CNT_HI, 16'h0007);
		wr_reg(ADDR_CTRL0, 8'h00);
		wr_reg(ADDR_CTRL0, 8'h78);
		partner.pulse(3);
		rd16(ADDR_CNT_HI, 16'h0003);
		summarize();
	end
endmodule
`default_nettype wire
